// *** nvm_access_pkg.sv ***
/*
 Package for the program/data nonvolatile access controller: field layouts, unlock codes, timing.
 Assumes a 50 MHz core clock, one core instruction per clock edge at the register ports.
*/
package nvm_access_pkg;
	localparam int unsigned ADDR_W        = 13;
	localparam int unsigned WORD_W        = 14;
	localparam int unsigned LOW_W         = 8;
	localparam int unsigned HIGH_W        = 6;
	localparam int unsigned DEPTH         = 8192;
	localparam int unsigned EE_ADDR_W     = 8;
	localparam logic [7:0]  UNLOCK_FIRST  = 8'h55;
	localparam logic [7:0]  UNLOCK_SECOND = 8'haa;
	localparam int unsigned READ_CYCLES   = 2;
	localparam int unsigned WRITE_CYCLES  = 2;
	localparam logic [1:0]  CNT_ONE       = 2'h1;
	localparam int unsigned CLK_MHZ       = 50;
	localparam int unsigned PWRT_MS       = 72;
	localparam int unsigned PWRT_CYCLES   = PWRT_MS * 1000 * CLK_MHZ;
	localparam int unsigned PWRT_W        = 22;
	localparam logic [5:0]  CP_NONE       = 6'h00;

	typedef enum logic [1:0] {
		UNL_IDLE = 2'b00,
		UNL_GOT1 = 2'b01,
		UNL_ARM  = 2'b10
	} unlock_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_READ  = 2'b01,
		ST_WRITE = 2'b10
	} state_t;
endpackage : nvm_access_pkg

// *** flash_word_mem.sv ***
/*
 Program word memory: one synchronous write port, registered read data.
 Assumes enables from the same clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
module flash_word_mem (
	input  wire logic                                  clk,
	input  wire logic                                  rdEn,
	input  wire logic                                  write_enable_bit,
	input  wire logic [nvm_access_pkg::ADDR_W-1:0]     addr,
	input  wire logic [nvm_access_pkg::WORD_W-1:0]     wrData,
	output var  logic [nvm_access_pkg::WORD_W-1:0]     rdData
);
	logic [nvm_access_pkg::WORD_W-1:0] mem [nvm_access_pkg::DEPTH];

	always_ff @(posedge clk) begin
		if (write_enable_bit) begin
			mem[addr] <= wrData;
		end
		if (rdEn) begin
			rdData <= mem[addr];
		end
	end
endmodule : flash_word_mem
`default_nettype wire

// *** program_flash_access_control.sv ***
/*
 Self-access controller for program flash words: read, unlocked write, core stall, spurious write guards.
 Assumes one core instruction per clock; register write strobes are single-cycle pulses from core logic.
*/
`timescale 1ns/1ns
`default_nettype none
module program_flash_access_control #(
	parameter int unsigned PWRT_COUNT = nvm_access_pkg::PWRT_CYCLES
) (
	input  wire logic                                clk,
	input  wire logic                                rst,
	input  wire logic                                addrLowWr,
	input  wire logic                                addrHighWr,
	input  wire logic                                dataLowWr,
	input  wire logic                                dataHighWr,
	input  wire logic                                controlWr,
	input  wire logic                                unlockWr,
	input  wire logic [7:0]                          busWrData,
	input  wire logic                                flagClear,
	input  wire logic                                selfWritePermitCfg,
	input  wire logic [5:0]                          codeProtectCfg,
	input  wire logic                                dataProtectCfg,
	input  wire logic                                extProgReq,
	output var  logic [7:0]                          addrLow_q,
	output var  logic [4:0]                          addrHigh_q,
	output var  logic [7:0]                          dataLow_q,
	output var  logic [5:0]                          dataHigh_q,
	output var  logic                                programSpaceSelect_q,
	output var  logic                                writeEnableBit_q,
	output var  logic                                writeStart_q,
	output var  logic                                readStart_q,
	output var  logic                                writeDoneFlag_q,
	output var  logic                                coreStall_q,
	output var  logic                                powerUpActive_q,
	output var  logic                                dataWriteReq_q,
	output var  logic                                extAccessAllowed_q
);
	////////////////////////////////////////////////////////////////////////
	// Decode
	nvm_access_pkg::state_t  state_q, state_d;
	nvm_access_pkg::unlock_t unl_q, unl_d;
	logic [1:0]                                 cnt_q;
	logic [nvm_access_pkg::PWRT_W-1:0]          pwrt_q;
	logic [nvm_access_pkg::WORD_W-1:0]          memRd;
	logic [nvm_access_pkg::ADDR_W-1:0]          wordAddr;
	logic [2:0]                                 segment;
	logic                                       segProtected;
	logic                                       idle;
	logic                                       readReq;
	logic                                       writeReq;
	logic                                       progWriteOk;
	logic                                       busyDone;
	logic                                       readDone;
	logic                                       writeDone;
	logic                                       dataWrite;

	assign wordAddr     = {addrHigh_q, addrLow_q};
	assign segment      = wordAddr[nvm_access_pkg::ADDR_W-1 -: 3];
	assign segProtected = codeProtectCfg[segment[2:1] + 2'h0] | (codeProtectCfg != nvm_access_pkg::CP_NONE
	                      && &codeProtectCfg);
	assign idle         = state_q == nvm_access_pkg::ST_IDLE;
	assign readReq      = idle && controlWr && busWrData[0];
	assign writeReq     = idle && controlWr && busWrData[1] && unl_q == nvm_access_pkg::UNL_ARM
	                      && writeEnableBit_q;
	assign progWriteOk  = selfWritePermitCfg && !segProtected;
	assign busyDone     = cnt_q == nvm_access_pkg::CNT_ONE;
	assign readDone     = state_q == nvm_access_pkg::ST_READ && busyDone;
	assign writeDone    = state_q == nvm_access_pkg::ST_WRITE && busyDone;
	assign dataWrite    = writeReq && !busWrData[7] && !powerUpActive_q;

	////////////////////////////////////////////////////////////////////////
	// Unlock sequencer
	always_comb begin
		unl_d = nvm_access_pkg::UNL_IDLE;
		if (unlockWr && busWrData == nvm_access_pkg::UNLOCK_FIRST) begin
			unl_d = nvm_access_pkg::UNL_GOT1;
		end else if (unlockWr && busWrData == nvm_access_pkg::UNLOCK_SECOND && unl_q == nvm_access_pkg::UNL_GOT1) begin
			unl_d = nvm_access_pkg::UNL_ARM;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_comb begin
		state_d = state_q;
		case (state_q)
			nvm_access_pkg::ST_IDLE: begin
				if (readReq && busWrData[7]) begin
					state_d = nvm_access_pkg::ST_READ;
				end else if (writeReq && busWrData[7]) begin
					state_d = nvm_access_pkg::ST_WRITE;
				end
			end
			nvm_access_pkg::ST_READ,
			nvm_access_pkg::ST_WRITE: begin
				if (busyDone) begin
					state_d = nvm_access_pkg::ST_IDLE;
				end
			end
			default: state_d = nvm_access_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= nvm_access_pkg::ST_IDLE;
			unl_q   <= nvm_access_pkg::UNL_IDLE;
			cnt_q   <= 2'h0;
		end else begin
			state_q <= state_d;
			unl_q   <= unl_d;
			// two fetch cycles; two stall cycles
			if (idle && state_d != nvm_access_pkg::ST_IDLE) begin
				cnt_q <= (state_d == nvm_access_pkg::ST_WRITE) ? 2'(nvm_access_pkg::WRITE_CYCLES)
				         : 2'(nvm_access_pkg::READ_CYCLES);
			end else if (!idle) begin
				cnt_q <= cnt_q - 2'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Address, data and control registers
	always_ff @(posedge clk) begin
		if (rst) begin
			addrLow_q            <= 8'h00;
			addrHigh_q           <= 5'h00;
			programSpaceSelect_q <= 1'b0;
		end else begin
			if (addrLowWr) begin
				addrLow_q <= busWrData;
			end
			if (addrHighWr) begin
				addrHigh_q <= busWrData[4:0];
			end
			if (controlWr && idle) begin
				programSpaceSelect_q <= busWrData[7];
			end
		end
	end

	// hold until read or user write
	always_ff @(posedge clk) begin
		if (rst) begin
			dataLow_q  <= 8'h00;
			dataHigh_q <= 6'h00;
		end else if (readDone) begin
			dataLow_q  <= memRd[nvm_access_pkg::LOW_W-1:0];
			dataHigh_q <= memRd[nvm_access_pkg::WORD_W-1:nvm_access_pkg::LOW_W];
		end else begin
			if (dataLowWr) begin
				dataLow_q <= busWrData;
			end
			if (dataHighWr) begin
				dataHigh_q <= busWrData[5:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			writeEnableBit_q <= 1'b0;
			writeStart_q     <= 1'b0;
			readStart_q      <= 1'b0;
			writeDoneFlag_q  <= 1'b0;
			coreStall_q      <= 1'b0;
			dataWriteReq_q   <= 1'b0;
		end else begin
			if (controlWr) begin
				writeEnableBit_q <= busWrData[2];
			end
			readStart_q  <= state_d == nvm_access_pkg::ST_READ;
			writeStart_q <= state_d == nvm_access_pkg::ST_WRITE || dataWrite;
			writeDoneFlag_q <= writeDone || dataWriteReq_q ? 1'b1
			                   : (flagClear ? 1'b0 : writeDoneFlag_q);
			// stall core; clock not gated; resume third
			coreStall_q <= state_d == nvm_access_pkg::ST_WRITE;
			// data writes blocked by timer; data protect ignored
			dataWriteReq_q <= dataWrite;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Power-up timer and external access gate
	always_ff @(posedge clk) begin
		if (rst) begin
			pwrt_q          <= '0;
			powerUpActive_q <= 1'b1;
		end else if (powerUpActive_q) begin
			pwrt_q          <= pwrt_q + 1'b1;
			powerUpActive_q <= pwrt_q < nvm_access_pkg::PWRT_W'(PWRT_COUNT - 1);
		end
	end

	// protected block denies external access; config only from pins
	always_ff @(posedge clk) begin
		if (rst) begin
			extAccessAllowed_q <= 1'b0;
		end else begin
			extAccessAllowed_q <= extProgReq && !segProtected && (programSpaceSelect_q || !dataProtectCfg);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Word store
	flash_word_mem u_mem (
		.clk    (clk),
		.rdEn   (state_q == nvm_access_pkg::ST_READ),
		.write_enable_bit   (writeDone && progWriteOk),
		.addr   (wordAddr),
		.wrData ({dataHigh_q, dataLow_q}),
		.rdData (memRd)
	);

	////////////////////////////////////////////////////////////////////////
	// Checks
	sequence unlockSeq;
		unl_q == nvm_access_pkg::UNL_ARM;
	endsequence

	readLen_a: assert property (@(posedge clk) disable iff (rst) readReq && busWrData[7] |=> readStart_q [*2] ##1 !readStart_q)
		else $error("read fetch length wrong");
	readLatency_a: assert property (@(posedge clk) disable iff (rst) readReq && busWrData[7] |-> ##2 readDone)
		else $error("read result late");
	stallLen_a: assert property (@(posedge clk) disable iff (rst) writeReq && busWrData[7] |=> coreStall_q ##1 coreStall_q ##1 !coreStall_q)
		else $error("stall length wrong");
	unlockNeed_a: assert property (@(posedge clk) disable iff (rst) $rose(writeStart_q) |-> $past(unl_q) == nvm_access_pkg::UNL_ARM)
		else $error("write without unlock");
	enableNeed_a: assert property (@(posedge clk) disable iff (rst) $rose(writeStart_q) |-> $past(writeEnableBit_q))
		else $error("write without enable");
	doneFlag_a: assert property (@(posedge clk) disable iff (rst) writeDone |=> writeDoneFlag_q && !writeStart_q)
		else $error("write end not flagged");
	permitGate_a: assert property (@(posedge clk) disable iff (rst) writeDone && !selfWritePermitCfg |-> !u_mem.write_enable_bit)
		else $error("write without permit");
	protGate_a: assert property (@(posedge clk) disable iff (rst) segProtected |=> !extAccessAllowed_q)
		else $error("protected external access");
	pwrtBlock_a: assert property (@(posedge clk) disable iff (rst) powerUpActive_q |=> !dataWriteReq_q)
		else $error("data write in power-up");
	holdData_a: assert property (@(posedge clk) disable iff (rst) !readDone && !dataLowWr |=> $stable(dataLow_q))
		else $error("data register changed");
	armUse_a: assert property (@(posedge clk) disable iff (rst) unlockSeq |=> unl_q != nvm_access_pkg::UNL_ARM)
		else $error("unlock held too long");
endmodule : program_flash_access_control
`default_nettype wire

// *** tb_program_flash_access_control.sv ***
/*
 Self-checking bench for the program flash access controller: reset, reads, unlocked writes, guards.
 Assumes one strobe taken per clock edge and a shortened power-up count.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_program_flash_access_control;
	localparam int unsigned PWRT = 16;
	logic       clk, rst, flagClear, permit, dataProt, extReq;
	logic [5:0] strb, cpCfg;
	logic [7:0] busData, aLo, dLo;
	logic [4:0] aHi;
	logic [5:0] dHi;
	logic       pSel, wEn, wStart, rStart, wDone, stall, pwrUp, dReq, extOk;
	int         errCount = 0;
	int         nTests = 0;

	program_flash_access_control #(.PWRT_COUNT(PWRT)) uut (
		.clk(clk), .rst(rst), .addrLowWr(strb[0]), .addrHighWr(strb[1]), .dataLowWr(strb[2]),
		.dataHighWr(strb[3]), .controlWr(strb[4]), .unlockWr(strb[5]), .busWrData(busData),
		.flagClear(flagClear), .selfWritePermitCfg(permit), .codeProtectCfg(cpCfg),
		.dataProtectCfg(dataProt), .extProgReq(extReq), .addrLow_q(aLo), .addrHigh_q(aHi),
		.dataLow_q(dLo), .dataHigh_q(dHi), .programSpaceSelect_q(pSel), .writeEnableBit_q(wEn),
		.writeStart_q(wStart), .readStart_q(rStart), .writeDoneFlag_q(wDone), .coreStall_q(stall),
		.powerUpActive_q(pwrUp), .dataWriteReq_q(dReq), .extAccessAllowed_q(extOk));

	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		nTests++;
		if (got !== exp) begin
			errCount++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic put(input int idx, input logic [7:0] d);
		@(posedge clk);
		strb    <= 6'h01 << idx;
		busData <= d;
	endtask : put

	task automatic idle();
		@(posedge clk);
		strb <= 6'h00;
	endtask : idle

	task automatic step();
		@(posedge clk);
		#1;
	endtask : step

	task automatic clearFlag();
		@(posedge clk);
		flagClear <= 1'b1;
		@(posedge clk);
		flagClear <= 1'b0;
		step();
		chk("flag cleared", 0, wDone);
	endtask : clearFlag

	////////////////////////////////////////////////////////////////
	task automatic readWord(input logic [12:0] a, input logic [13:0] exp);
		put(0, a[7:0]);
		put(1, {3'h0, a[12:8]});
		put(4, 8'h85);
		idle();
		#1;
		chk("read busy 1", 1, rStart);
		chk("read address", a, {aHi, aLo});
		chk("read program select", 1, pSel);
		step();
		chk("read busy 2", 1, rStart);
		step();
		chk("read idle", 0, rStart);
		chk("read word", exp, {dHi, dLo});
		repeat (2) step();
		chk("read word held", exp, {dHi, dLo});
		$display("done read %h", a);
	endtask : readWord

	task automatic writeWord(input logic [12:0] a, input logic [13:0] w, input logic [7:0] key, input logic go);
		put(0, a[7:0]);
		put(1, {3'h0, a[12:8]});
		put(2, w[7:0]);
		put(3, {2'h0, w[13:8]});
		put(4, 8'h84);
		put(5, key);
		put(5, 8'haa);
		put(4, 8'h86);
		idle();
		#1;
		chk("write started", go, wStart);
		chk("stall 1", go, stall);
		chk("data regs loaded", w, {dHi, dLo});
		step();
		chk("stall 2", go, stall);
		step();
		chk("stall over", 0, stall);
		chk("start cleared", 0, wStart);
		chk("done flag", go, wDone);
		if (go) clearFlag();
		$display("done write %h", a);
	endtask : writeWord

	task automatic noEnable();
		put(4, 8'h80);
		put(5, 8'h55);
		put(5, 8'haa);
		put(4, 8'h86);
		idle();
		step();
		chk("start without enable", 0, wStart);
		chk("stall without enable", 0, stall);
		$display("done enable guard");
	endtask : noEnable

	task automatic dataWrite(input logic exp);
		logic seen;
		seen = 1'b0;
		put(4, 8'h04);
		put(5, 8'h55);
		put(5, 8'haa);
		put(4, 8'h06);
		idle();
		#1;
		seen = (dReq === 1'b1);
		repeat (5) begin
			step();
			seen = seen | (dReq === 1'b1);
		end
		chk("data write request", exp, seen);
		clearFlag();
		$display("done data write");
	endtask : dataWrite

	task automatic extAccess(input logic [5:0] cp, input logic dp, input logic exp);
		@(posedge clk);
		extReq   <= 1'b1;
		cpCfg    <= cp;
		dataProt <= dp;
		repeat (2) step();
		chk("external access", exp, extOk);
		$display("done external access");
	endtask : extAccess

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", nTests, errCount);
		if (errCount == 0 && nTests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : complete_run

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (3000) @(posedge clk);
		errCount++;
		complete_run();
	end

	initial begin
		{rst, strb, busData, flagClear, permit, cpCfg, dataProt, extReq} = '0;
		rst = 1'b1;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		step();
		chk("reset enable", 0, wEn);
		chk("reset power-up", 1, pwrUp);
		chk("reset flags", 0, {wStart, rStart, wDone, stall});
		dataWrite(1'b0);
		for (int i = 0; i < 40 && pwrUp !== 1'b0; i++) step();
		chk("power-up over", 0, pwrUp);
		dataProt <= 1'b1;
		dataWrite(1'b1);
		dataProt <= 1'b0;
		permit   <= 1'b1;
		writeWord(13'h0123, 14'h2a5c, 8'h55, 1'b1);
		writeWord(13'h1c05, 14'h15a3, 8'h55, 1'b1);
		readWord(13'h0123, 14'h2a5c);
		readWord(13'h1c05, 14'h15a3);
		writeWord(13'h0123, 14'h3fff, 8'h54, 1'b0);
		noEnable();
		readWord(13'h0123, 14'h2a5c);
		permit <= 1'b0;
		writeWord(13'h0123, 14'h0001, 8'h55, 1'b1);
		readWord(13'h0123, 14'h2a5c);
		permit <= 1'b1;
		cpCfg  <= 6'h08;
		writeWord(13'h1c05, 14'h0abc, 8'h55, 1'b1);
		readWord(13'h1c05, 14'h15a3);
		extAccess(6'h00, 1'b0, 1'b1);
		extAccess(6'h08, 1'b0, 1'b0);
		put(4, 8'h00);
		idle();
		extAccess(6'h00, 1'b1, 1'b0);
		extAccess(6'h00, 1'b0, 1'b1);
		complete_run();
	end
endmodule : tb_program_flash_access_control
`default_nettype wire
